// [hw/spj_jog.v]
`timescale 1ns/1ps
`include "spj_consts.vh"
//
// Summary of operation
// (R1) Long press: start frequency half second, then accelerate
// (R2) Hold jog frequency while command stays high
// (R3) Command low: decelerate to start frequency
// (R4) Limit reached at ramp end: output off
// (R5) Else run at start frequency to limit
// (R6) Job running flag while job active
// (R7) Parameter error output for invalid settings
// (R8) Enable falling clears the job state
// (R9) Ramp changes are millihertz per emitted step
// (R10) Short press: limit steps at start frequency
// (R11) Host keeps jog above start, within 5000 Hz
// (R12) Bad frequencies raise error, refuse start
//
module spj_jog #(
  parameter HOLD_CYCLES = `SPJ_HOLD_CYCLES,
  parameter CLK_HZ      = `SPJ_CLK_HZ
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  output reg         pulse_pin_out,
  output wire        job_running,
  output wire        param_error,
  output wire        irq
);
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_START = 3'h1;
  localparam [2:0] ST_ACCEL = 3'h2;
  localparam [2:0] ST_JOG   = 3'h3;
  localparam [2:0] ST_DECEL = 3'h4;
  localparam [2:0] ST_TAIL  = 3'h5;

  reg  [31:0] start_frequency;
  reg  [31:0] jog_frequency;
  reg  [15:0] accel_step_change;
  reg  [15:0] decel_step_change;
  reg  [31:0] jog_step_limit;
  reg         enable;
  reg         jog_command;
  reg         enable_d;
  reg         cmd_d;
  reg  [2:0]  state;
  reg  [31:0] current_output_frequency;
  reg  [31:0] steps_done;
  reg  [31:0] hold_cnt;
  reg         long_press;
  reg  [2:0]  irq_mask;
  reg  [31:0] next_freq;
  wire        step;
  wire [2:0]  irq_status;
  wire [2:0]  irq_event;
  wire [2:0]  irq_clear;
  wire        wr_en;
  wire        limit_hit;
  wire        job_start;
  wire        job_done;

  // Register address compare shared by read and write paths
  function hit;
    input [11:0] a;
    input [11:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, unmapped reads return zero
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wr_en   = psel & penable & pwrite;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      enable            <= 1'b0;
      jog_command       <= 1'b0;
      start_frequency   <= `SPJ_START_FREQ_RST;
      jog_frequency     <= `SPJ_JOG_FREQ_RST;
      accel_step_change <= `SPJ_ACCEL_RST;
      decel_step_change <= `SPJ_DECEL_RST;
      jog_step_limit    <= `SPJ_STEP_LIMIT_RST;
      irq_mask          <= 3'h0;
    end
    else if (wr_en)
    begin
      if (hit(paddr, `SPJ_REG_CTRL))
      begin
        enable      <= pwdata[`SPJ_CTRL_EN_BIT];
        jog_command <= pwdata[`SPJ_CTRL_JOG_BIT];
      end
      if (hit(paddr, `SPJ_REG_START_FREQ))
        start_frequency <= pwdata;
      if (hit(paddr, `SPJ_REG_JOG_FREQ))
        jog_frequency <= pwdata;
      if (hit(paddr, `SPJ_REG_ACCEL))
        accel_step_change <= pwdata[15:0];
      if (hit(paddr, `SPJ_REG_DECEL))
        decel_step_change <= pwdata[15:0];
      if (hit(paddr, `SPJ_REG_STEP_LIMIT))
        jog_step_limit <= pwdata;
      if (hit(paddr, `SPJ_REG_IRQ_MASK))
        irq_mask <= pwdata[2:0];
    end
  end

  assign irq_clear = (wr_en && hit(paddr, `SPJ_REG_IRQ_STAT)) ? pwdata[2:0] : 3'h0;

  // Read data is registered so it stays stable during the access phase
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite)
    begin
      case (1'b1)
        hit(paddr, `SPJ_REG_CTRL):       prdata <= {30'h0, jog_command, enable};
        hit(paddr, `SPJ_REG_START_FREQ): prdata <= start_frequency;
        hit(paddr, `SPJ_REG_JOG_FREQ):   prdata <= jog_frequency;
        hit(paddr, `SPJ_REG_ACCEL):      prdata <= {16'h0000, accel_step_change};
        hit(paddr, `SPJ_REG_DECEL):      prdata <= {16'h0000, decel_step_change};
        hit(paddr, `SPJ_REG_STEP_LIMIT): prdata <= jog_step_limit;
        hit(paddr, `SPJ_REG_STATUS):     prdata <= {27'h0, state, param_error, job_running};
        hit(paddr, `SPJ_REG_IRQ_STAT):   prdata <= {29'h0, irq_status};
        hit(paddr, `SPJ_REG_IRQ_MASK):   prdata <= {29'h0, irq_mask};
        hit(paddr, `SPJ_REG_FREQ_NOW):   prdata <= current_output_frequency;
        hit(paddr, `SPJ_REG_STEPS_DONE): prdata <= steps_done;
        default:                         prdata <= 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Parameter check; frequencies are held in Hz and scaled to mHz below
  assign param_error = (jog_frequency <= start_frequency) ||
                       (jog_frequency > `SPJ_FREQ_MAX_HZ) ||
                       (start_frequency > `SPJ_FREQ_MAX_HZ);              // R7 R11

  assign limit_hit   = (steps_done >= jog_step_limit);
  assign job_start   = enable && jog_command && !cmd_d && (state == ST_IDLE)
                       && !param_error;                                   // R12
  assign job_running = (state != ST_IDLE);                                 // R6

  // Next frequency after a step on a ramp, clamped to the ramp target
  always @*
  begin
    next_freq = current_output_frequency;
    if (state == ST_ACCEL)
    begin
      if (current_output_frequency + accel_step_change >= jog_frequency * 1000)
        next_freq = jog_frequency * 1000;                                  // R1
      else
        next_freq = current_output_frequency + accel_step_change;          // R9
    end
    else if (state == ST_DECEL)
    begin
      if (current_output_frequency <= start_frequency * 1000 + decel_step_change)
        next_freq = start_frequency * 1000;                                // R3
      else
        next_freq = current_output_frequency - decel_step_change;          // R9
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Jog sequencer
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state                    <= ST_IDLE;
      current_output_frequency <= 32'h00000000;
      steps_done               <= 32'h00000000;
      hold_cnt                 <= 32'h00000000;
      long_press               <= 1'b0;
      enable_d                 <= 1'b0;
      cmd_d                    <= 1'b0;
    end
    else
    begin
      enable_d <= enable;
      cmd_d    <= jog_command;
      if (!enable)
      begin
        // Enable low stops output at once and clears the job
        state                    <= ST_IDLE;                               // R8
        current_output_frequency <= 32'h00000000;
        steps_done               <= 32'h00000000;
        hold_cnt                 <= 32'h00000000;
        long_press               <= 1'b0;
      end
      else
      begin
        if (step)
          steps_done <= steps_done + 32'h00000001;
        case (state)
          ST_IDLE:
          begin
            if (job_start)
            begin
              state                    <= ST_START;
              steps_done               <= 32'h00000000;
              hold_cnt                 <= 32'h00000000;
              long_press               <= 1'b0;
              current_output_frequency <= start_frequency * 1000;
            end
          end
          ST_START:
          begin
            // Short press runs the step limit at start frequency only
            if (!jog_command && !long_press)
              state <= ST_TAIL;                                            // R10
            else if (hold_cnt >= HOLD_CYCLES - 1)
            begin
              long_press <= 1'b1;
              state      <= ST_ACCEL;                                      // R1
            end
            else
              hold_cnt <= hold_cnt + 32'h00000001;
            if (limit_hit && !jog_command)
              state <= ST_IDLE;
          end
          ST_ACCEL:
          begin
            if (!jog_command)
              state <= ST_DECEL;                                           // R3
            else if (current_output_frequency >= jog_frequency * 1000)
              state <= ST_JOG;                                             // R2
            else if (step)
              current_output_frequency <= next_freq;                       // R1
          end
          ST_JOG:
          begin
            if (!jog_command)
              state <= ST_DECEL;                                           // R2 R3
          end
          ST_DECEL:
          begin
            if (current_output_frequency <= start_frequency * 1000)
            begin
              if (limit_hit)
                state <= ST_IDLE;                                          // R4
              else
                state <= ST_TAIL;                                          // R5
            end
            else if (step)
              current_output_frequency <= next_freq;                       // R3
          end
          ST_TAIL:
          begin
            if (limit_hit)
              state <= ST_IDLE;                                            // R5 R10
          end
          default:
            state <= ST_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Step pulses; output is gated off as soon as the job leaves running
  spj_pulse_gen #(
    .CLK_HZ   (CLK_HZ)
  ) u_pulse (
    .pclk     (pclk),
    .presetn  (presetn),
    .run      (job_running),
    .freq_mhz (current_output_frequency),
    .step     (step)
  );

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pulse_pin_out <= 1'b0;
    else
      pulse_pin_out <= step & job_running;                                 // R4 R5
  end

  ////////////////////////////////////////////////////////////////////
  // Events: job done, start refused for bad parameters, enable dropped
  assign irq_event[`SPJ_IRQ_DONE_BIT] = job_running && (state != ST_START) && limit_hit
                                        && ((state == ST_TAIL) || (state == ST_DECEL));
  assign irq_event[`SPJ_IRQ_ERR_BIT]  = enable && jog_command && !cmd_d && param_error;
  assign irq_event[`SPJ_IRQ_TOP_BIT]  = enable_d && !enable;               // R8

  spj_irq #(
    .N        (3)
  ) u_irq (
    .pclk     (pclk),
    .presetn  (presetn),
    .event_in (irq_event),
    .clear    (irq_clear),
    .mask     (irq_mask),
    .status   (irq_status),
    .irq      (irq)
  );
endmodule // spj_jog

// [hw/spj_consts.vh]
`ifndef SPJ_CONSTS_VH
`define SPJ_CONSTS_VH
// Clock and timing
`define SPJ_CLK_HZ          100000000
`define SPJ_HOLD_MS         500
`define SPJ_HOLD_CYCLES     ((`SPJ_CLK_HZ / 1000) * `SPJ_HOLD_MS)
`define SPJ_FREQ_MAX_HZ     5000
// APB register byte offsets
`define SPJ_REG_CTRL        12'h000
`define SPJ_REG_START_FREQ  12'h004
`define SPJ_REG_JOG_FREQ    12'h008
`define SPJ_REG_ACCEL       12'h00C
`define SPJ_REG_DECEL       12'h010
`define SPJ_REG_STEP_LIMIT  12'h014
`define SPJ_REG_STATUS      12'h018
`define SPJ_REG_IRQ_STAT    12'h01C
`define SPJ_REG_IRQ_MASK    12'h020
`define SPJ_REG_FREQ_NOW    12'h024
`define SPJ_REG_STEPS_DONE  12'h028
// Control fields
`define SPJ_CTRL_EN_BIT     0
`define SPJ_CTRL_JOG_BIT    1
// Status / interrupt fields
`define SPJ_ST_RUN_BIT      0
`define SPJ_ST_ERR_BIT      1
`define SPJ_IRQ_DONE_BIT    0
`define SPJ_IRQ_ERR_BIT     1
`define SPJ_IRQ_TOP_BIT     2
// Reset values
`define SPJ_START_FREQ_RST  32'h000000C8
`define SPJ_JOG_FREQ_RST    32'h000003E8
`define SPJ_ACCEL_RST       16'h01F4
`define SPJ_DECEL_RST       16'h07D0
`define SPJ_STEP_LIMIT_RST  32'h00001770
`endif

// [hw/spj_pulse_gen.v]
`timescale 1ns/1ps
`include "spj_consts.vh"
// Emits one step pulse per period of the requested frequency in mHz.
module spj_pulse_gen #(
  parameter CLK_HZ = `SPJ_CLK_HZ
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        run,
  input  wire [31:0] freq_mhz,
  output reg         step
);
  localparam [47:0] CLK_MHZ = CLK_HZ * 48'd1000;
  reg [47:0] acc;
  reg [47:0] next_acc;

  // Phase accumulator; an exact ratio avoids drift over long jobs
  always @*
  begin
    next_acc = acc + {16'h0000, freq_mhz};
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc  <= 48'h000000000000;
      step <= 1'b0;
    end
    else if (!run)
    begin
      acc  <= 48'h000000000000;
      step <= 1'b0;
    end
    else if (next_acc >= CLK_MHZ)
    begin
      acc  <= next_acc - CLK_MHZ;
      step <= 1'b1;
    end
    else
    begin
      acc  <= next_acc;
      step <= 1'b0;
    end
  end
endmodule // spj_pulse_gen

// [hw/spj_irq.v]
`timescale 1ns/1ps
`include "spj_consts.vh"
// Sticky event bits, write-one-to-clear, masked onto one level output.
module spj_irq #(
  parameter N = 3
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire [N-1:0] event_in,
  input  wire [N-1:0] clear,
  input  wire [N-1:0] mask,
  output reg  [N-1:0] status,
  output wire         irq
);
  // Set wins over a clear in the same cycle so no event is lost
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status <= {N{1'b0}};
    else
      status <= (status & ~clear) | event_in;
  end

  assign irq = |(status & mask);
endmodule // spj_irq

// [sim/spj_drive_model.sv]
`timescale 1ns/1ps
// Stepper drive: counts step pulses and times the gap between them
module spj_drive_model (
  input wire pclk,
  input wire presetn,
  input wire step_in
);
  int steps;
  int gap;
  int since;

  // Gap in clock cycles between the last two pulses shows the rate
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      steps <= 0;
      gap   <= 0;
      since <= 0;
    end
    else if (step_in)
    begin
      steps <= steps + 1;
      gap   <= since + 1;
      since <= 0;
    end
    else
      since <= since + 1;
  end
endmodule // spj_drive_model

// [sim/spj_jog_properties.sv]
`timescale 1ns/1ps
module spj_jog_props (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        pulse_pin_out,
  input wire        job_running,
  input wire        param_error,
  input wire        irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Control writes as seen on the bus
  wire ctl_wr = psel && penable && pwrite && paddr == 12'h000;
  wire en_off = ctl_wr && !pwdata[0];
  wire go_wr  = ctl_wr && pwdata[1:0] == 2'h3;
  ////////////////////////////////////////
  // Stopping takes two steps: the job drops, then the pin goes quiet
  sequence s_stop;
    ##[1:2] !job_running;
  endsequence
  sequence s_quiet;
    ##2 !pulse_pin_out [*5];
  endsequence
  property p_en_off;
    en_off |-> s_stop ##0 s_quiet;
  endproperty
  a_en_off: assert property (p_en_off)
    else $error("job kept running after enable dropped");
  property p_start;
    $rose(job_running) |-> $past(go_wr) || $past(go_wr, 2);
  endproperty
  a_start: assert property (p_start)
    else $error("job started without a jog command");
  property p_no_err_start;
    $rose(job_running) |-> !$past(param_error);
  endproperty
  a_no_err_start: assert property (p_no_err_start)
    else $error("job started with bad parameters");
  property p_refuse;
    go_wr && param_error |-> !job_running [*3];
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("refused start still ran");
  property p_pulse_width;
    pulse_pin_out |=> !pulse_pin_out;
  endproperty
  a_pulse_width: assert property (p_pulse_width)
    else $error("step pulse longer than one cycle");
  property p_pulse_job;
    pulse_pin_out |-> job_running || $past(job_running);
  endproperty
  a_pulse_job: assert property (p_pulse_job)
    else $error("step pulse outside a job");
  property p_idle_reset;
    $rose(presetn) |-> !job_running && !pulse_pin_out && !irq;
  endproperty
  a_idle_reset: assert property (p_idle_reset)
    else $error("outputs active after reset");
  property p_unmapped;
    psel && penable && !pwrite && paddr > 12'h028 |-> prdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_ready;
    psel |-> pready && !pslverr;
  endproperty
  a_ready: assert property (p_ready)
    else $error("bus not ready or error");
endmodule // spj_jog_props

bind spj_jog spj_jog_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pulse_pin_out(pulse_pin_out),
  .job_running(job_running), .param_error(param_error), .irq(irq));

// [sim/tb.sv]
`timescale 1ns/1ps
`include "spj_consts.vh"
module tb;
  // Slow clock figure keeps step periods short: 200 Hz is 100 cycles
  localparam HOLD = 200;
  localparam CLKHZ = 20000;
  reg         pclk, presetn, psel, penable, pwrite;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, rd;
  wire [31:0] prdata;
  wire        pready, pslverr, pulse_pin_out, job_running, param_error, irq;
  integer     n_fail, check_count, i, base;

  spj_jog #(.HOLD_CYCLES(HOLD), .CLK_HZ(CLKHZ)) uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pulse_pin_out(pulse_pin_out),
    .job_running(job_running), .param_error(param_error), .irq(irq));
  spj_drive_model m (.pclk(pclk), .presetn(presetn), .step_in(pulse_pin_out));
  ////////////////////////////////////////
  task wrap_up;
  begin
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask
  task chk(input string what, input [31:0] exp, input [31:0] got);
  begin
    check_count = check_count + 1;
    if (got !== exp)
    begin
      n_fail = n_fail + 1;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  end
  endtask
  // Checks land at the falling edge so the design's updates have settled
  task cyc(input integer c);
  begin
    repeat (c) @(posedge pclk);
    @(negedge pclk);
  end
  endtask
  // One APB transfer; read data taken at the edge that samples pready
  task apb(input w, input [11:0] a, input [31:0] d);
    integer k;
  begin
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k = k + 1;
    end
    while (pready !== 1'b1 && k < 20);
    if (k == 20)
    begin
      chk("pready", 1, 0);
      wrap_up;
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  end
  endtask
  task wait_idle(input integer lim);
    integer k;
  begin
    k = 0;
    while (job_running !== 1'b0 && k < lim)
    begin
      @(negedge pclk);
      k = k + 1;
    end
    chk("job end", 0, job_running);
    if (job_running !== 1'b0)
      wrap_up;
  end
  endtask
  task wait_freq(input [31:0] f);
    integer k;
  begin
    k = 0;
    do
    begin
      apb(0, `SPJ_REG_FREQ_NOW, 0);
      k = k + 1;
    end
    while (rd !== f && k < 1000);
    chk("freq", f, rd);
    if (rd !== f)
      wrap_up;
  end
  endtask
  task gap_chk(input integer e);
    chk("gap", 1, m.gap >= e - 1 && m.gap <= e + 1);
  endtask
  ////////////////////////////////////////
  initial
  begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = 0;
    n_fail = 0;
    check_count = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 5; i = i + 1)
    begin
      apb(0, `SPJ_REG_START_FREQ + 4 * i, 0);
      chk("reset value", i == 0 ? `SPJ_START_FREQ_RST : i == 1 ? `SPJ_JOG_FREQ_RST :
        i == 2 ? `SPJ_ACCEL_RST : i == 3 ? `SPJ_DECEL_RST : `SPJ_STEP_LIMIT_RST, rd);
    end
    apb(1, 12'h100, 32'hFFFFFFFF);
    apb(0, 12'h100, 0);
    chk("unmapped", 0, rd);
    // Ramp fields are 16 bits wide: 40 Hz and 50 Hz per step
    apb(1, `SPJ_REG_ACCEL, 32'h00009C40);
    apb(1, `SPJ_REG_DECEL, 32'h0000C350);
    $display("test registers done");
    // Short press: limit steps at start rate, no ramps
    apb(1, `SPJ_REG_STEP_LIMIT, 10);
    base = m.steps;
    apb(1, `SPJ_REG_CTRL, 1);
    apb(1, `SPJ_REG_CTRL, 3);
    cyc(20);
    chk("running", 1, job_running);
    apb(1, `SPJ_REG_CTRL, 1);
    wait_idle(3000);
    chk("short steps", 10, m.steps - base);
    gap_chk(100);
    $display("test short press done");
    // Long press, limit not reached at end of braking
    apb(1, `SPJ_REG_STEP_LIMIT, 60);
    base = m.steps;
    apb(1, `SPJ_REG_CTRL, 3);
    cyc(150);
    apb(0, `SPJ_REG_FREQ_NOW, 0);
    chk("hold freq", 32'h00030D40, rd);
    wait_freq(32'h0003A980);
    wait_freq(32'h000F4240);
    cyc(60);
    gap_chk(20);
    apb(1, `SPJ_REG_CTRL, 1);
    wait_freq(32'h000E7EF0);
    wait_freq(32'h00030D40);
    chk("running", 1, job_running);
    cyc(250);
    gap_chk(100);
    wait_idle(8000);
    chk("long steps", 60, m.steps - base);
    $display("test long press done");
    // Long press past the limit: off when braking ends
    apb(1, `SPJ_REG_STEP_LIMIT, 8);
    base = m.steps;
    apb(1, `SPJ_REG_CTRL, 3);
    cyc(HOLD + 600);
    apb(1, `SPJ_REG_CTRL, 1);
    wait_idle(1000);
    apb(0, `SPJ_REG_FREQ_NOW, 0);
    chk("off at start", 32'h00030D40, rd);
    chk("over limit", 1, m.steps - base >= 8);
    $display("test limit passed done");
    // Enable dropped mid-job
    apb(1, `SPJ_REG_STEP_LIMIT, 60);
    apb(1, `SPJ_REG_CTRL, 3);
    cyc(300);
    apb(1, `SPJ_REG_CTRL, 0);
    cyc(10);
    chk("stopped", 0, job_running);
    apb(0, `SPJ_REG_STEPS_DONE, 0);
    chk("steps cleared", 0, rd);
    apb(0, `SPJ_REG_IRQ_STAT, 0);
    chk("drop event", 1, rd[2]);
    $display("test enable drop done");
    // Bad frequencies: error, refusal, interrupt raise, mask and clear
    apb(1, `SPJ_REG_IRQ_STAT, 7);
    apb(1, `SPJ_REG_JOG_FREQ, 200);
    chk("param error", 1, param_error);
    apb(1, `SPJ_REG_IRQ_MASK, 7);
    apb(1, `SPJ_REG_CTRL, 1);
    apb(1, `SPJ_REG_CTRL, 3);
    cyc(5);
    chk("refused", 0, job_running);
    apb(0, `SPJ_REG_IRQ_STAT, 0);
    chk("refuse event", 2, rd);
    chk("irq", 1, irq);
    apb(1, `SPJ_REG_IRQ_MASK, 0);
    chk("irq masked", 0, irq);
    apb(1, `SPJ_REG_IRQ_STAT, 2);
    apb(0, `SPJ_REG_IRQ_STAT, 0);
    chk("cleared", 0, rd);
    apb(1, `SPJ_REG_JOG_FREQ, 1000);
    apb(1, `SPJ_REG_START_FREQ, 6000);
    chk("range error", 1, param_error);
    apb(1, `SPJ_REG_START_FREQ, 200);
    chk("no error", 0, param_error);
    $display("test parameters done");
    wrap_up;
  end
endmodule // tb
